// ---- spi_master_model.sv ----
// Behavioural outside master for the serial port link.
// Assumes the slave shifts out MSB first, changing after rising clock.
`default_nettype none

module spi_master_model (
	// Link pins, master side
	output logic o_sck,
	output logic o_select_n,
	output logic o_data_out,
	input wire logic i_data_in,
	input wire logic i_data_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================================
	// Idle levels
	// Clock stands low between frames
	initial begin
		o_sck = 1'b0;
		o_select_n = 1'b1;
		o_data_out = 1'b0;
	end

	// ==========================================================
	// Clock pulses with select high
	// Lets the slave sync its active flag before a real frame
	task automatic prime();
		repeat (4) begin
			#6 o_sck = 1'b1;
			#6 o_sck = 1'b0;
		end
	endtask : prime

	// One whole 16-bit word, 12 ns period, MSB first
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx, output logic oe);
		o_select_n = 1'b0;
		// Enable is synced in the core, so wait well past its latency
		#500 oe = i_data_oe;
		for (int i = 15; i >= 0; i--) begin
			o_data_out = tx[i];
			// Undriven line reads as the inverse so a stale bit is never taken for data
			#6 rx[i] = i_data_oe ? i_data_in : ~i_data_in;
			o_sck = 1'b1;
			#6 o_sck = 1'b0;
		end
		#6 o_select_n = 1'b1;
		// Released line shows the inverse so stale data is not mistaken
		o_data_out = ~o_data_out;
	endtask : frame

endmodule : spi_master_model

`default_nettype wire

// ---- spi_status_control.sv ----
// Status and control logic of a serial port, slave side of the link.
// Assumes a register port on i_core_clk and an outside master that
// drives i_sck during frames of whole 16-bit words, plus priming pulses with select high.
//
// Added by the designer: the register offsets and strobed register access.
`default_nettype none

module spi_status_control (
	// Core clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Register port
	input wire logic [1:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// System state
	input wire logic i_idle,
	// Link pins
	input wire logic i_sck,
	input wire logic i_select_n,
	input wire logic i_serial_in,
	output logic o_serial_out,
	output logic o_serial_out_oe,
	output logic o_pins_owned,
	// Buffer interrupt
	output logic o_buf_irq
);

	// ==========================================================
	// Core-domain state
	logic port_module_on_q, port_module_on_d;
	logic halt_in_idle_q, halt_in_idle_d;
	logic enh_mode_q, enh_mode_d;
	logic [2:0] buffer_irq_select_q, buffer_irq_select_d;
	logic rx_overflow_flag_q, rx_overflow_flag_d;
	logic tx_buffer_full_flag_q, tx_buffer_full_flag_d;
	logic rx_buffer_full_flag_q, rx_buffer_full_flag_d;
	logic busy_q, busy_d;
	logic [15:0] tx_buf_q, tx_buf_d;
	logic [15:0] rx_buf_q, rx_buf_d;
	logic tx_tgl_q, tx_tgl_d;
	logic active_q, active_d;
	logic [2:0] word_s_q, word_s_d;
	logic [1:0] sel_s_q, sel_s_d;
	logic [15:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic oe_q, oe_d;
	logic ev_word;
	logic wr_data_ok;

	// ==========================================================
	// Link-domain state
	logic [1:0] act_l_q, act_l_d;
	logic [1:0] req_l_q, req_l_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [15:0] rx_sh_q, rx_sh_d;
	logic [15:0] shift_register_q, shift_register_d;
	logic [15:0] slot0_q, slot0_d;
	logic [15:0] slot1_q, slot1_d;
	logic word_tgl_q, word_tgl_d;
	logic ack_q, ack_d;
	logic loaded_q, loaded_d;

	// Adds the two occupancy flags into the element count
	function automatic logic [2:0] pending_count(input logic a, input logic b);
		pending_count = {2'h0, a} + {2'h0, b};
	endfunction : pending_count

	// ==========================================================
	// Link side: shifting on the master's clock
	// Words land in two alternating slots so the core has a full word
	// time to fetch one before it is reused.
	always_comb begin
		act_l_d = {act_l_q[0], active_q};
		req_l_d = {req_l_q[0], tx_tgl_q};
		bit_cnt_d = bit_cnt_q;
		rx_sh_d = rx_sh_q;
		shift_register_d = shift_register_q;
		slot0_d = slot0_q;
		slot1_d = slot1_q;
		word_tgl_d = word_tgl_q;
		ack_d = ack_q;
		loaded_d = loaded_q;
		if (!act_l_q[1]) begin
			bit_cnt_d = spi_status_control_pkg::BIT_CNT_ZERO;
		end else if (!i_select_n) begin
			bit_cnt_d = bit_cnt_q + 4'h1;
			rx_sh_d = {rx_sh_q[14:0], i_serial_in};
			shift_register_d = {shift_register_q[14:0], 1'h0};
			if (bit_cnt_q == spi_status_control_pkg::BIT_CNT_LAST) begin
				if (word_tgl_q) begin
					slot1_d = {rx_sh_q[14:0], i_serial_in};
				end else begin
					slot0_d = {rx_sh_q[14:0], i_serial_in};
				end
				word_tgl_d = ~word_tgl_q;
				if (req_l_q[1] != ack_q) begin
					shift_register_d = tx_buf_q;
					loaded_d = 1'h1;
					ack_d = req_l_q[1];
				end else begin
					shift_register_d = spi_status_control_pkg::WORD_ZERO;
					loaded_d = 1'h0;
				end
			end
		end
	end

	// Link registers, cleared only by the system reset; the bit count also clears while the port is inactive
	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			act_l_q <= 2'h0;
			req_l_q <= 2'h0;
			bit_cnt_q <= spi_status_control_pkg::BIT_CNT_ZERO;
			rx_sh_q <= spi_status_control_pkg::WORD_ZERO;
			shift_register_q <= spi_status_control_pkg::WORD_ZERO;
			slot0_q <= spi_status_control_pkg::WORD_ZERO;
			slot1_q <= spi_status_control_pkg::WORD_ZERO;
			word_tgl_q <= 1'h0;
			ack_q <= 1'h0;
			loaded_q <= 1'h0;
		end else begin
			act_l_q <= act_l_d;
			req_l_q <= req_l_d;
			bit_cnt_q <= bit_cnt_d;
			rx_sh_q <= rx_sh_d;
			shift_register_q <= shift_register_d;
			slot0_q <= slot0_d;
			slot1_q <= slot1_d;
			word_tgl_q <= word_tgl_d;
			ack_q <= ack_d;
			loaded_q <= loaded_d;
		end
	end

	assign o_serial_out = shift_register_q[15]; // Straight from the shifter flop

	// ==========================================================
	// Core side: word event and flags
	assign ev_word = word_s_q[2] ^ word_s_q[1];
	assign wr_data_ok = i_wr && (i_addr == spi_status_control_pkg::REG_DATA)
		&& port_module_on_q && !tx_buffer_full_flag_q;

	always_comb begin
		word_s_d = {word_s_q[1:0], word_tgl_q};
		sel_s_d = {sel_s_q[0], i_select_n};
		port_module_on_d = port_module_on_q;
		halt_in_idle_d = halt_in_idle_q;
		enh_mode_d = enh_mode_q;
		buffer_irq_select_d = buffer_irq_select_q;
		rx_overflow_flag_d = rx_overflow_flag_q;
		tx_buffer_full_flag_d = tx_buffer_full_flag_q;
		rx_buffer_full_flag_d = rx_buffer_full_flag_q;
		busy_d = busy_q;
		tx_buf_d = tx_buf_q;
		rx_buf_d = rx_buf_q;
		tx_tgl_d = tx_tgl_q;
		// halt only when bit is set
		// Idle stops port when halt set
		active_d = port_module_on_q && !(i_idle && halt_in_idle_q);
		oe_d = active_q && !sel_s_q[1];
		if (i_wr && (i_addr == spi_status_control_pkg::REG_STATUS)) begin
			port_module_on_d = i_wdata[spi_status_control_pkg::BIT_ON];
			halt_in_idle_d = i_wdata[spi_status_control_pkg::BIT_HALT];
			buffer_irq_select_d =
				i_wdata[spi_status_control_pkg::SEL_MSB:spi_status_control_pkg::SEL_LSB];
			if (!i_wdata[spi_status_control_pkg::BIT_OVF]) begin
				rx_overflow_flag_d = 1'h0;
			end
		end
		// enhanced mode in its own register
		if (i_wr && (i_addr == spi_status_control_pkg::REG_MODE)) begin
			enh_mode_d = i_wdata[spi_status_control_pkg::BIT_ENH];
		end
		// a status write cannot set either full flag; a data write sets transmit full
		if (wr_data_ok) begin
			tx_buf_d = i_wdata;
			tx_tgl_d = ~tx_tgl_q;
			tx_buffer_full_flag_d = 1'h1;
		end
		if (i_rd && (i_addr == spi_status_control_pkg::REG_DATA)) begin
			rx_buffer_full_flag_d = 1'h0;
		end
		if (ev_word && active_q) begin
			busy_d = loaded_q;
			if (loaded_q) begin
				tx_buffer_full_flag_d = 1'h0;
			end
			// new word dropped, flag set wins
			if (rx_buffer_full_flag_q && !(i_rd && (i_addr == spi_status_control_pkg::REG_DATA))) begin
				rx_overflow_flag_d = 1'h1;
			end else begin
				rx_buf_d = word_s_q[1] ? slot0_q : slot1_q;
				rx_buffer_full_flag_d = 1'h1;
			end
		end
		// off clears both full flags and busy; a transmit request already raised to the link stays pending
		if (!port_module_on_q) begin
			tx_buffer_full_flag_d = 1'h0;
			rx_buffer_full_flag_d = 1'h0;
			busy_d = 1'h0;
		end
	end

	// Core registers, all with defined reset values
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			word_s_q <= 3'h0;
			sel_s_q <= 2'h3;
			port_module_on_q <= 1'h0;
			halt_in_idle_q <= 1'h0;
			enh_mode_q <= 1'h0;
			buffer_irq_select_q <= spi_status_control_pkg::SEL_NONE;
			rx_overflow_flag_q <= 1'h0;
			tx_buffer_full_flag_q <= 1'h0;
			rx_buffer_full_flag_q <= 1'h0;
			busy_q <= 1'h0;
			tx_buf_q <= spi_status_control_pkg::WORD_ZERO;
			rx_buf_q <= spi_status_control_pkg::WORD_ZERO;
			tx_tgl_q <= 1'h0;
			active_q <= 1'h0;
			oe_q <= 1'h0;
		end else begin
			word_s_q <= word_s_d;
			sel_s_q <= sel_s_d;
			port_module_on_q <= port_module_on_d;
			halt_in_idle_q <= halt_in_idle_d;
			enh_mode_q <= enh_mode_d;
			buffer_irq_select_q <= buffer_irq_select_d;
			rx_overflow_flag_q <= rx_overflow_flag_d;
			tx_buffer_full_flag_q <= tx_buffer_full_flag_d;
			rx_buffer_full_flag_q <= rx_buffer_full_flag_d;
			busy_q <= busy_d;
			tx_buf_q <= tx_buf_d;
			rx_buf_q <= rx_buf_d;
			tx_tgl_q <= tx_tgl_d;
			active_q <= active_d;
			oe_q <= oe_d;
		end
	end

	// ==========================================================
	// Read data and buffer interrupt
	// Count and empty fields read zero outside enhanced mode.
	always_comb begin
		rdata_d = spi_status_control_pkg::WORD_ZERO;
		if (i_rd && (i_addr == spi_status_control_pkg::REG_STATUS)) begin
			rdata_d[spi_status_control_pkg::BIT_ON] = port_module_on_q;
			rdata_d[spi_status_control_pkg::BIT_HALT] = halt_in_idle_q;
			if (enh_mode_q) begin
				rdata_d[spi_status_control_pkg::BEC_MSB:spi_status_control_pkg::BEC_LSB] =
					pending_count(tx_buffer_full_flag_q, busy_q);
			end
			rdata_d[spi_status_control_pkg::BIT_SH_EMPTY] = enh_mode_q && !busy_q;
			rdata_d[spi_status_control_pkg::BIT_OVF] = rx_overflow_flag_q;
			rdata_d[spi_status_control_pkg::BIT_RX_EMPTY] = enh_mode_q && !rx_buffer_full_flag_q;
			rdata_d[spi_status_control_pkg::SEL_MSB:spi_status_control_pkg::SEL_LSB] =
				buffer_irq_select_q;
			rdata_d[spi_status_control_pkg::BIT_TX_FULL] = tx_buffer_full_flag_q;
			rdata_d[spi_status_control_pkg::BIT_RX_FULL] = rx_buffer_full_flag_q;
		end else if (i_rd && (i_addr == spi_status_control_pkg::REG_DATA)) begin
			rdata_d = rx_buf_q;
		end else if (i_rd && (i_addr == spi_status_control_pkg::REG_MODE)) begin
			rdata_d[spi_status_control_pkg::BIT_ENH] = enh_mode_q;
		end
		irq_d = 1'h0;
		if (!enh_mode_q) begin
			irq_d = ev_word && active_q; // Plain mode: every finished word
		end else begin
			case (spi_status_control_pkg::irq_sel_t'(buffer_irq_select_q))
				spi_status_control_pkg::SEL_TX_FULL: irq_d = wr_data_ok;
				spi_status_control_pkg::SEL_TX_EMPTY: irq_d = ev_word && active_q && loaded_q;
				spi_status_control_pkg::SEL_TX_DONE: irq_d = ev_word && active_q && !loaded_q;
				spi_status_control_pkg::SEL_TX_ONE_OPEN: irq_d = ev_word && active_q && loaded_q;
				spi_status_control_pkg::SEL_RX_FULL: irq_d = rx_buffer_full_flag_d
					&& !rx_buffer_full_flag_q;
				spi_status_control_pkg::SEL_RX_AVAIL: irq_d = rx_buffer_full_flag_q;
				spi_status_control_pkg::SEL_RX_ANY: irq_d = rx_buffer_full_flag_q;
				default: irq_d = 1'h0;
			endcase
		end
	end

	// Output flops for the register port and interrupt
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= spi_status_control_pkg::WORD_ZERO;
			irq_q <= 1'h0;
		end else begin
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_buf_irq = irq_q;
	assign o_serial_out_oe = oe_q;
	assign o_pins_owned = active_q;

	// ==========================================================
	// Checks on the core domain
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	a_ovf_on_arrival: assert property (
		ev_word && active_q && port_module_on_q && rx_buffer_full_flag_q && !i_rd
		|=> rx_overflow_flag_q && $stable(rx_buf_q))
		else $error("overflow not flagged on arrival");
	a_rx_full_set: assert property (
		ev_word && active_q && port_module_on_q && !rx_buffer_full_flag_q
		|=> rx_buffer_full_flag_q)
		else $error("receive full not set");
	a_off_drops: assert property (
		!port_module_on_q
		|=> !tx_buffer_full_flag_q && !rx_buffer_full_flag_q && !o_pins_owned)
		else $error("port off kept state");
	a_idle_halts: assert property (
		halt_in_idle_q && i_idle |=> !o_pins_owned ##1 !o_serial_out_oe)
		else $error("port ran during idle");
	a_idle_runs: assert property (
		port_module_on_q && !halt_in_idle_q |=> o_pins_owned)
		else $error("port stopped without halt");
	a_tx_full_irq: assert property (
		enh_mode_q && buffer_irq_select_q == 3'h7 && wr_data_ok
		|=> o_buf_irq && tx_buffer_full_flag_q)
		else $error("transmit full irq missing");
	a_count_read: assert property (
		i_rd && i_addr == 2'h0 && enh_mode_q && tx_buffer_full_flag_q && busy_q
		|=> o_rdata[10:8] == 3'h2)
		else $error("element count wrong");
	a_rx_empty_read: assert property (
		i_rd && i_addr == 2'h0 && enh_mode_q |=> o_rdata[5] == !$past(rx_buffer_full_flag_q))
		else $error("receive empty flag wrong");
	a_avail_level: assert property (
		enh_mode_q && buffer_irq_select_q == 3'h1 && rx_buffer_full_flag_q |=> o_buf_irq)
		else $error("data available irq missing");
	a_enh_off_fields: assert property (
		i_rd && i_addr == 2'h0 && !enh_mode_q |=> o_rdata[10:7] == 4'h0 && !o_rdata[5])
		else $error("enhanced fields active outside mode");

endmodule : spi_status_control

`default_nettype wire

// ---- spi_status_control_pkg.sv ----
// Constants shared by the serial port status and control block.
// Assumes a plain register port with word indices, 16-bit data.
`default_nettype none

package spi_status_control_pkg;

	// ==========================================================
	// Register indices (plain register port)
	localparam int ADDR_W = 2;
	localparam int DATA_W = 16;
	localparam logic [1:0] REG_STATUS = 2'h0;
	localparam logic [1:0] REG_DATA = 2'h1;
	localparam logic [1:0] REG_MODE = 2'h2;

	// ==========================================================
	// Status/control field positions
	localparam int BIT_ON = 15;
	localparam int BIT_HALT = 13;
	localparam int BEC_MSB = 10;
	localparam int BEC_LSB = 8;
	localparam int BIT_SH_EMPTY = 7;
	localparam int BIT_OVF = 6;
	localparam int BIT_RX_EMPTY = 5;
	localparam int SEL_MSB = 4;
	localparam int SEL_LSB = 2;
	localparam int BIT_TX_FULL = 1;
	localparam int BIT_RX_FULL = 0;
	localparam int BIT_ENH = 0;

	// ==========================================================
	// Reset values and word constants
	localparam logic [15:0] WORD_ZERO = 16'h0000;
	localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
	localparam logic [3:0] BIT_CNT_LAST = 4'hf;
	localparam logic [2:0] COUNT_ZERO = 3'h0;

	// ==========================================================
	// Buffer interrupt conditions
	typedef enum logic [2:0] {
		SEL_NONE = 3'h0,
		SEL_RX_AVAIL = 3'h1,
		SEL_RX_ANY = 3'h2,
		SEL_RX_FULL = 3'h3,
		SEL_TX_ONE_OPEN = 3'h4,
		SEL_TX_DONE = 3'h5,
		SEL_TX_EMPTY = 3'h6,
		SEL_TX_FULL = 3'h7
	} irq_sel_t;

endpackage : spi_status_control_pkg

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the serial port status and control block.
// Assumes the behavioural master model drives the link pins.
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic i_core_clk, i_rst_n, i_wr, i_rd, i_idle;
	logic [1:0] i_addr;
	logic [15:0] i_wdata, o_rdata, rx;
	logic o_serial_out, o_serial_out_oe, o_pins_owned, o_buf_irq;
	logic sck, sel_n, mosi, oe, irq_q;
	int n_mismatch = 0, checked = 0, n_irq = 0, base;
	logic [4:0] tbl [10] = '{5'h00, 5'h05, 5'h09, 5'h0d, 5'h10, 5'h15, 5'h18, 5'h13,
		5'h16, 5'h1b};

	// ==========================================================
	// Instances
	spi_status_control i_spi_status_control (
		.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle), .i_sck(sck),
		.i_select_n(sel_n), .i_serial_in(mosi), .o_serial_out(o_serial_out),
		.o_serial_out_oe(o_serial_out_oe), .o_pins_owned(o_pins_owned), .o_buf_irq(o_buf_irq)
	);
	spi_master_model i_spi_master_model (
		.o_sck(sck), .o_select_n(sel_n), .o_data_out(mosi), .i_data_in(o_serial_out),
		.i_data_oe(o_serial_out_oe)
	);

	// ==========================================================
	// Clock and interrupt edge counter
	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	// Counting rises works for pulse and level selects alike
	always @(posedge i_core_clk) begin
		irq_q <= o_buf_irq;
		if (o_buf_irq === 1'b1 && irq_q === 1'b0) n_irq <= n_irq + 1;
	end

	// ==========================================================
	// Bus tasks
	// Idle cycle after a write keeps strobes from being set twice at once
	task automatic wr(input logic [1:0] a, input logic [15:0] w);
		i_addr <= a;
		i_wdata <= w;
		i_wr <= 1'b1;
		@(posedge i_core_clk) i_wr <= 1'b0;
		@(posedge i_core_clk);
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [15:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk) i_rd <= 1'b0;
		@(posedge i_core_clk) `CHK(o_rdata, e)
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask : cyc
	task automatic complete_run();
		if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run

	// ==========================================================
	// Watchdog, far beyond the expected 34 us
	initial begin
		#300us n_mismatch++;
		complete_run();
	end

	// ==========================================================
	// Main sequence
	initial begin
		i_rst_n <= 1'b0;
		i_addr <= 2'h0;
		i_wdata <= 16'h0000;
		i_wr <= 1'b0;
		i_rd <= 1'b0;
		i_idle <= 1'b0;
		cyc(4);
		i_rst_n <= 1'b1;
		cyc(1);
		rd(spi_status_control_pkg::REG_STATUS, 16'h0000);
		rd(spi_status_control_pkg::REG_MODE, 16'h0000);
		rd(2'h3, 16'h0000);
		// Read-only bits and overflow set are not writable
		wr(spi_status_control_pkg::REG_STATUS, 16'hffff);
		rd(spi_status_control_pkg::REG_STATUS, 16'ha01c);
		wr(spi_status_control_pkg::REG_MODE, 16'h0001);
		rd(spi_status_control_pkg::REG_STATUS, 16'ha0bc);
		cyc(4);
		`CHK(o_pins_owned, 1'b1)
		i_spi_master_model.prime();
		// Back onto the core clock edge before the next bus access
		cyc(1);
		base = n_irq;
		wr(spi_status_control_pkg::REG_DATA, 16'ha5c3);
		// Second word is refused while the transmit buffer is full
		wr(spi_status_control_pkg::REG_DATA, 16'h1111);
		rd(spi_status_control_pkg::REG_STATUS, 16'ha1be);
		`CHK(n_irq - base, 1)
		i_spi_master_model.frame(16'h3c5a, rx, oe);
		`CHK(oe, 1'b1)
		cyc(5);
		rd(spi_status_control_pkg::REG_STATUS, 16'ha11d);
		rd(spi_status_control_pkg::REG_DATA, 16'h3c5a);
		rd(spi_status_control_pkg::REG_STATUS, 16'ha13c);
		i_spi_master_model.frame(16'h0f0f, rx, oe);
		`CHK(rx, 16'ha5c3)
		cyc(5);
		rd(spi_status_control_pkg::REG_STATUS, 16'ha09d);
		// Unread word, then another arrives
		i_spi_master_model.frame(16'hf0f0, rx, oe);
		cyc(5);
		rd(spi_status_control_pkg::REG_STATUS, 16'ha0dd);
		rd(spi_status_control_pkg::REG_DATA, 16'h0f0f);
		wr(spi_status_control_pkg::REG_STATUS, 16'ha01c);
		rd(spi_status_control_pkg::REG_STATUS, 16'ha0bc);
		// Each entry: select, whether a word is pending, and interrupt rises expected
		for (int k = 0; k < 10; k++) begin
			wr(spi_status_control_pkg::REG_STATUS, {11'h400, tbl[k][4:2], 2'h0});
			// Pending word, plus a shifter still loaded when the previous round had a pending word
			if (tbl[k][1]) begin
				wr(spi_status_control_pkg::REG_DATA, 16'h5a5a);
				rd(spi_status_control_pkg::REG_STATUS, {1'b1, 4'h0,
					(tbl[k - 1][1] ? 3'h2 : 3'h1), !tbl[k - 1][1], 2'h1, tbl[k][4:2],
					2'h2});
			end
			base = n_irq;
			i_spi_master_model.frame(16'h1234, rx, oe);
			cyc(5);
			rd(spi_status_control_pkg::REG_DATA, 16'h1234);
			cyc(3);
			`CHK(n_irq - base, int'(tbl[k][0]))
		end
		// Halt in Idle, then keep running through Idle
		wr(spi_status_control_pkg::REG_STATUS, 16'ha000);
		i_idle <= 1'b1;
		cyc(6);
		`CHK(o_pins_owned, 1'b0)
		i_spi_master_model.frame(16'h4321, rx, oe);
		`CHK(oe, 1'b0)
		cyc(5);
		// Shifter still holds the last loaded word, so one transfer pends
		rd(spi_status_control_pkg::REG_STATUS, 16'ha120);
		wr(spi_status_control_pkg::REG_STATUS, 16'h8000);
		cyc(6);
		`CHK(o_pins_owned, 1'b1)
		i_idle <= 1'b0;
		i_spi_master_model.prime();
		cyc(1);
		// Plain mode: enhanced fields read 0, each word interrupts
		wr(spi_status_control_pkg::REG_MODE, 16'h0000);
		base = n_irq;
		i_spi_master_model.frame(16'h8421, rx, oe);
		cyc(5);
		rd(spi_status_control_pkg::REG_STATUS, 16'h8001);
		rd(spi_status_control_pkg::REG_DATA, 16'h8421);
		`CHK(n_irq - base, 1)
		// Port off: pins released, data and link ignored
		wr(spi_status_control_pkg::REG_STATUS, 16'h0000);
		cyc(6);
		`CHK(o_pins_owned, 1'b0)
		wr(spi_status_control_pkg::REG_DATA, 16'h7777);
		i_spi_master_model.frame(16'h6666, rx, oe);
		`CHK(oe, 1'b0)
		cyc(5);
		rd(spi_status_control_pkg::REG_STATUS, 16'h0000);
		complete_run();
	end

endmodule : tb_top

`default_nettype wire
